/* File: tbt_timebase.sv */
// Trigger flag, auto-trigger timeout, indicator, ramp rate code and expansion latches.
// Assumes write chain and read address signals come from the store board, asynchronous.
//
// What this block does
// - In refreshed and roll modes, timeout drives brightline_enable low after 200 ms without write activity; normal mode follows the off switch.
// - Each write activity pulse retriggers the timeout, holding brightline_enable high in refreshed and roll modes.
// - Falling trigger edge sets triggered_flag unless hold-off is asserted.
// - Hold-off blocks both trigger edges and automatic trigger.
// - Auto trigger is a level set without edges, only when off switch not pulled.
// - Auto trigger suppressed whenever brightline_enable is high.
// - Off switch also disables timeout auto trigger in refreshed and roll modes.
// - Low reset input forces triggered_flag low.
// - Indicator lit while edges arrive, dark after a short quiet interval.
// - Negative slope inverts trigger; line source reverses slope sense.
// - Rate code 01=400, 10=100, 11=80 us/cm; 00 not allowed.
// - Read address advances one sample per microsecond.
// - Whole memory view forces both rate select bits high.
// - X4/X5 choice is OR of divide-by-2.5 and divide-by-5, latched.
// - Two expansion latches for even and odd sweeps.
// - Alternate sample freeze stops clocking the first latch.
// - Halted write chain stops both latch clocks.
// - Without freeze both latches load identical values.
// - Modified read address LSB selects which latch drives the rate code.
// - Refreshed mode: sweep end bit falling sets hold-off, clearing triggered_flag.
`timescale 1ns/1ns
module tbt_timebase #(
    parameter int unsigned AUTO_CYC = tbt_pkg::AUTO_TIMEOUT_CYC,
    parameter int unsigned IND_CYC  = tbt_pkg::IND_HOLD_CYC
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic                     trig_comp,
    input  wire logic                     slope_neg,
    input  wire logic                     src_line,
    input  wire logic                     write_activity_pulse,
    input  wire logic                     write_sweep_end_bit,
    input  wire logic                     write_halted,
    input  wire logic                     flag_reset_n,
    input  wire logic                     holdoff_ext,
    input  wire logic                     brightline_off_switch,
    input  wire logic                     mode_refresh,
    input  wire logic                     mode_roll,
    input  wire logic                     whole_memory_view_n,
    input  wire logic                     div_2p5_sel,
    input  wire logic                     div_5_sel,
    input  wire logic                     alt_sample_freeze,
    input  wire logic                     sweep_start,
    input  wire logic                     read_lsb_mod,
    output logic                          triggered_flag,
    output logic                          brightline_enable,
    output logic                          trig_indicator,
    output logic                          holdoff,
    output logic                          rate_select_p,
    output logic                          rate_select_q,
    output logic [tbt_pkg::ADDR_W-1:0]    read_addr
);
    // Synchronised copies of pin inputs
    logic                  trig_s;
    logic                  wap_s;
    logic                  wseb_s;
    logic                  halt_s;
    logic                  frn_s;
    logic                  hox_s;
    logic                  offsw_s;
    logic                  wmv_n_s;
    logic                  frz_s;
    logic                  d25_s;
    logic                  d5_s;
    logic                  sst_s;
    logic                  lsb_s;
    logic                  neg_s;
    logic                  line_s;
    logic                  mref_s;
    logic                  mroll_s;
    // One-cycle-old copies for edge detection
    logic                  trig_d_ff;
    logic                  wap_d_ff;
    logic                  wseb_d_ff;
    logic                  sst_d_ff;
    logic                  shaped;
    logic                  trig_fall;
    logic                  wap_rise;
    logic                  sweep_end_fall;
    logic                  sweep_edge;
    logic                  auto_expired;
    logic                  ind_expired;
    logic                  auto_trig;
    tbt_pkg::tbt_mode_type mode_ff;
    logic                  exp_even_ff;
    logic                  exp_odd_ff;
    logic                  nxt_exp_sel;
    logic [7:0]            smp_cnt_ff;
    logic                  sync_in  [17];
    logic                  sync_out [17];

    assign sync_in = '{trig_comp, write_activity_pulse, write_sweep_end_bit, write_halted,
                       flag_reset_n, holdoff_ext, brightline_off_switch,
                       whole_memory_view_n, alt_sample_freeze, div_2p5_sel, div_5_sel,
                       sweep_start, read_lsb_mod, slope_neg, src_line, mode_refresh, mode_roll};

    generate
        for (genvar i = 0; i < 17; i++) begin : g_sync
            tbt_sync u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .din     (sync_in[i]),
                .dout    (sync_out[i])
            );
        end
    endgenerate

    assign trig_s  = sync_out[0];
    assign wap_s   = sync_out[1];
    assign wseb_s  = sync_out[2];
    assign halt_s  = sync_out[3];
    assign frn_s   = sync_out[4];
    assign hox_s   = sync_out[5];
    assign offsw_s = sync_out[6];
    assign wmv_n_s = sync_out[7];
    assign frz_s   = sync_out[8];
    assign d25_s   = sync_out[9];
    assign d5_s    = sync_out[10];
    assign sst_s   = sync_out[11];
    assign lsb_s   = sync_out[12];
    assign neg_s   = sync_out[13];
    assign line_s  = sync_out[14];
    assign mref_s  = sync_out[15];
    assign mroll_s = sync_out[16];

    // Line source is antiphase to the mains, so its slope sense flips
    assign shaped = trig_s ^ (neg_s ^ line_s);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_d_ff <= 1'h0;
            wap_d_ff  <= 1'h0;
            // Matches the synchroniser's reset output, so no false fall follows reset
            wseb_d_ff <= 1'h0;
            sst_d_ff  <= 1'h0;
        end else begin
            trig_d_ff <= shaped;
            wap_d_ff  <= wap_s;
            wseb_d_ff <= wseb_s;
            sst_d_ff  <= sst_s;
        end
    end

    assign trig_fall      = trig_d_ff & ~shaped;
    assign wap_rise       = wap_s & ~wap_d_ff;
    assign sweep_end_fall = wseb_d_ff & ~wseb_s;
    assign sweep_edge     = sst_s & ~sst_d_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= tbt_pkg::TBT_MODE_NORMAL;
        end else begin
            case ({mroll_s, mref_s})
                2'h1:    mode_ff <= tbt_pkg::TBT_MODE_REFRESH;
                2'h2:    mode_ff <= tbt_pkg::TBT_MODE_ROLL;
                default: mode_ff <= tbt_pkg::TBT_MODE_NORMAL;
            endcase
        end
    end

    // Auto-trigger timeout, reloaded by each write activity pulse
    tbt_timer #(.LOAD(AUTO_CYC)) u_auto (
        .ref_clk (ref_clk),
        .rst     (rst),
        .kick    (wap_rise),
        .expired (auto_expired)
    );

    // Edge-quiet detector for the indicator; shorter than the timeout
    tbt_timer #(.LOAD(IND_CYC)) u_ind (
        .ref_clk (ref_clk),
        .rst     (rst),
        .kick    (trig_fall),
        .expired (ind_expired)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            brightline_enable <= tbt_pkg::BLE_RST_VAL;
        end else if (mode_ff == tbt_pkg::TBT_MODE_NORMAL) begin
            brightline_enable <= offsw_s;
        end else begin
            // Switch pulled keeps the line high, killing auto trigger
            brightline_enable <= ~auto_expired | offsw_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_indicator <= 1'h0;
        end else begin
            trig_indicator <= ~ind_expired;
        end
    end

    // Auto trigger needs edges gone, the line low and the switch open
    assign auto_trig = ind_expired & ~brightline_enable & ~offsw_s;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            holdoff <= 1'h0;
        end else if (mode_ff == tbt_pkg::TBT_MODE_REFRESH && sweep_end_fall) begin
            holdoff <= 1'h1;
        end else if (!triggered_flag) begin
            holdoff <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            triggered_flag <= tbt_pkg::FLAG_RST_VAL;
        end else if (!frn_s || holdoff || hox_s) begin
            triggered_flag <= 1'h0;
        end else if (trig_fall || auto_trig) begin
            triggered_flag <= 1'h1;
        end
    end

    // Latch input and clock gating, both latches fed from one OR term
    assign nxt_exp_sel = d25_s | d5_s;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exp_even_ff <= 1'h0;
        end else if (sweep_edge && !halt_s && !frz_s) begin
            exp_even_ff <= nxt_exp_sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exp_odd_ff <= 1'h0;
        end else if (sweep_edge && !halt_s) begin
            exp_odd_ff <= nxt_exp_sel;
        end
    end

    // Rate code: expand selects 80 us/cm over 100 us/cm; 00 never driven
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rate_select_p <= 1'h0;
            rate_select_q <= 1'h1;
        end else if (!wmv_n_s) begin
            rate_select_p <= 1'h1;
            rate_select_q <= 1'h1;
        end else begin
            rate_select_p <= 1'h1;
            rate_select_q <= lsb_s ? exp_odd_ff : exp_even_ff;
        end
    end

    // Read address steps once per microsecond
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            smp_cnt_ff <= '0;
            read_addr  <= '0;
        end else if (smp_cnt_ff == 8'(tbt_pkg::SAMPLE_CYC - 1)) begin
            smp_cnt_ff <= '0;
            read_addr  <= read_addr + 1'b1;
        end else begin
            smp_cnt_ff <= smp_cnt_ff + 1'b1;
        end
    end
endmodule : tbt_timebase

/* File: tbt_pkg.sv */
// Shared constants for the timebase and trigger control block.
// Assumes a single 100 MHz system clock.
package tbt_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned AUTO_TIMEOUT_MS   = 200;
    localparam int unsigned AUTO_TIMEOUT_CYC  = (AUTO_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned IND_HOLD_MS       = 50;
    localparam int unsigned IND_HOLD_CYC      = (IND_HOLD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_PERIOD_US  = 1;
    localparam int unsigned SAMPLE_CYC        = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W             = 25;
    localparam int unsigned ADDR_W            = 10;
    localparam logic [1:0]  RATE_NONE         = 2'h0;
    localparam logic [1:0]  RATE_400US        = 2'h1;
    localparam logic [1:0]  RATE_100US        = 2'h2;
    localparam logic [1:0]  RATE_80US         = 2'h3;
    localparam logic        FLAG_RST_VAL      = 1'h0;
    localparam logic        BLE_RST_VAL       = 1'h1;

    typedef enum logic [2:0] {
        TBT_MODE_NORMAL = 3'h1,
        TBT_MODE_REFRESH = 3'h2,
        TBT_MODE_ROLL   = 3'h4
    } tbt_mode_type;
endpackage : tbt_pkg

/* File: tbt_sync.sv */
// Three-stage input synchroniser with second/third agreement filter.
// Assumes input is asynchronous to clk.
`timescale 1ns/1ns
module tbt_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_ff <= 1'h0;
            s2_ff <= 1'h0;
            s3_ff <= 1'h0;
            dout  <= 1'h0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // A change counts only once two settled stages agree
            if (s2_ff == s3_ff) begin
                dout <= s3_ff;
            end
        end
    end
endmodule : tbt_sync

/* File: tbt_timer.sv */
// Retriggerable down-counter: reloads on kick, flags expiry.
// Assumes kick is a one-cycle pulse on ref_clk.
`timescale 1ns/1ns
module tbt_timer #(
    parameter int unsigned LOAD = 16
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic kick,
    output logic      expired
);
    logic [tbt_pkg::CNT_W-1:0] cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff  <= '0;
            expired <= 1'h1;
        end else if (kick) begin
            cnt_ff  <= tbt_pkg::CNT_W'(LOAD);
            expired <= 1'h0;
        end else if (cnt_ff != '0) begin
            cnt_ff  <= cnt_ff - 1'b1;
            expired <= 1'h0;
        end else begin
            expired <= 1'h1;
        end
    end
endmodule : tbt_timer

/* File: tbt_timebase_properties.sv */
// Concurrent checks on the timebase block ports.
// Assumes one clock domain and reduced timeout counts in simulation.
`timescale 1ns/1ns
module tbt_timebase_properties #(
    parameter int unsigned AUTO_CYC = 200
) (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  trig_comp,
    input wire logic                  slope_neg,
    input wire logic                  src_line,
    input wire logic                  write_activity_pulse,
    input wire logic                  write_sweep_end_bit,
    input wire logic                  flag_reset_n,
    input wire logic                  holdoff_ext,
    input wire logic                  brightline_off_switch,
    input wire logic                  mode_refresh,
    input wire logic                  mode_roll,
    input wire logic                  whole_memory_view_n,
    input wire logic                  triggered_flag,
    input wire logic                  brightline_enable,
    input wire logic                  holdoff,
    input wire logic                  rate_select_p,
    input wire logic                  rate_select_q,
    input wire logic [tbt_pkg::ADDR_W-1:0] read_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    int unsigned quiet_ff;
    // Counts quiet refresh cycles; saturates so it never wraps
    always_ff @(posedge ref_clk) begin
        if (rst || !mode_refresh || mode_roll || write_activity_pulse || brightline_off_switch)
            quiet_ff <= 0;
        else if (quiet_ff < AUTO_CYC + 50)
            quiet_ff <= quiet_ff + 1;
    end
    AST_RATE_LEGAL: assert property (rate_select_p || rate_select_q)
        else $error("rate code 00 driven");
    AST_FULL_VIEW: assert property ((!whole_memory_view_n)[*8] |-> rate_select_p && rate_select_q)
        else $error("full view rate not 11");
    AST_HOLD_BLOCK: assert property (holdoff_ext[*8] |-> !triggered_flag)
        else $error("flag high under hold-off");
    AST_FLAG_CLR: assert property ((!flag_reset_n)[*8] |-> !triggered_flag)
        else $error("flag high under clear");
    AST_EDGE_SET: assert property (
        $fell(trig_comp) && slope_neg == src_line ##0 (flag_reset_n && !holdoff_ext && !holdoff)[*8]
        |-> triggered_flag) else $error("edge did not set flag");
    AST_TIMEOUT: assert property (quiet_ff > AUTO_CYC + 20 |-> !brightline_enable)
        else $error("timeout did not expire");
    AST_RETRIG: assert property (
        $rose(write_activity_pulse) && mode_refresh && !mode_roll |-> ##[5:12] brightline_enable)
        else $error("write pulse did not retrigger");
    AST_SWEEP_END: assert property (
        $fell(write_sweep_end_bit) && mode_refresh && !mode_roll |-> ##[3:10] holdoff)
        else $error("sweep end did not set hold-off");
    AST_ADDR_STEP: assert property (
        read_addr != $past(read_addr) |-> read_addr - $past(read_addr) == 10'h1)
        else $error("read address jumped");
endmodule : tbt_timebase_properties

/* File: tbt_store_model.sv */
// Store board model: write activity, sweep end, halt, sweep start, read LSB.
// Assumes the bench samples nothing from it; outputs change on falling edges.
`timescale 1ns/1ns
module tbt_store_model (
    input  wire logic ref_clk,
    input  wire logic write_run,
    input  wire logic lsb_sel,
    output logic      write_activity_pulse,
    output logic      write_sweep_end_bit,
    output logic      write_halted,
    output logic      sweep_start,
    output logic      read_lsb_mod
);
    logic [5:0] cnt_ff = 6'h0;
    logic [5:0] rd_ff  = 6'h0;
    always_ff @(negedge ref_clk) cnt_ff <= write_run ? cnt_ff + 6'h1 : 6'h0;
    // The read side keeps sweeping while writing is halted
    always_ff @(negedge ref_clk) rd_ff <= rd_ff + 6'h1;
    // Four-cycle pulses so they survive the input filter
    assign write_activity_pulse = write_run && cnt_ff[3:2] == 2'h3;
    assign write_sweep_end_bit  = !(write_run && cnt_ff[5:2] == 4'h7);
    assign write_halted         = !write_run;
    // Sweep starts go on during a halt, so latch clock gating is exercised
    assign sweep_start          = rd_ff[5];
    assign read_lsb_mod         = lsb_sel;
endmodule : tbt_store_model

/* File: tbt_timebase_tb_top.sv */
// Self-checking bench for the timebase block with the store board model.
// Assumes design, checker and model compiled first; inputs change on falling edges.
`timescale 1ns/1ns
module tbt_timebase_tb_top;
    localparam int unsigned AUTO = 200;
    localparam int unsigned IND  = 50;
    logic ref_clk = 1'b0, rst = 1'b1, trig_comp = 1'b1, slope_neg = 1'b0, src_line = 1'b0;
    logic flag_reset_n = 1'b1, holdoff_ext = 1'b0, brightline_off_switch = 1'b1;
    logic mode_refresh = 1'b0, mode_roll = 1'b0, whole_memory_view_n = 1'b1;
    logic div_2p5_sel = 1'b0, div_5_sel = 1'b0, alt_sample_freeze = 1'b0, run = 1'b0, odd = 1'b0;
    logic write_activity_pulse, write_sweep_end_bit, write_halted, sweep_start, read_lsb_mod;
    logic triggered_flag, brightline_enable, trig_indicator, holdoff, rate_select_p, rate_select_q;
    logic [tbt_pkg::ADDR_W-1:0] read_addr, a0;
    int fails = 0, checks = 0, cyc = 0;
    always #5 ref_clk = ~ref_clk;
    tbt_timebase #(.AUTO_CYC(AUTO), .IND_CYC(IND)) i_tbt_timebase (.ref_clk, .rst, .trig_comp,
        .slope_neg, .src_line, .write_activity_pulse, .write_sweep_end_bit, .write_halted,
        .flag_reset_n, .holdoff_ext, .brightline_off_switch, .mode_refresh, .mode_roll,
        .whole_memory_view_n, .div_2p5_sel, .div_5_sel, .alt_sample_freeze, .sweep_start,
        .read_lsb_mod, .triggered_flag, .brightline_enable, .trig_indicator, .holdoff,
        .rate_select_p, .rate_select_q, .read_addr);
    tbt_store_model i_tbt_store_model (.ref_clk, .write_run(run), .lsb_sel(odd),
        .write_activity_pulse, .write_sweep_end_bit, .write_halted, .sweep_start, .read_lsb_mod);
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : w
    task automatic chk(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task automatic chka(input logic [tbt_pkg::ADDR_W-1:0] e, input logic [tbt_pkg::ADDR_W-1:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error read_addr expected %h seen %h", e, g);
        end
    endtask : chka
    task automatic finish_test;
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic t_trig;
        for (int i = 0; i < 4; i++) begin
            flag_reset_n = 1'b0;
            w(1);
            {slope_neg, src_line} = i[1:0];
            trig_comp = ~(i[0] ^ i[1]);
            w(10);
            chk("flag cleared", 1'b0, triggered_flag);
            flag_reset_n = 1'b1;
            w(12);
            trig_comp = ~trig_comp;
            w(10);
            chk("flag set", 1'b1, triggered_flag);
            chk("indicator", 1'b1, trig_indicator);
        end
        w(IND + 30);
        chk("indicator off", 1'b0, trig_indicator);
        flag_reset_n = 1'b0;
        holdoff_ext = 1'b1;
        brightline_off_switch = 1'b0;
        w(10);
        flag_reset_n = 1'b1;
        trig_comp = 1'b1;
        w(5);
        trig_comp = 1'b0;
        w(IND + 30);
        chk("flag held off", 1'b0, triggered_flag);
        holdoff_ext = 1'b0;
        w(IND + 30);
        chk("auto flag", 1'b1, triggered_flag);
    endtask : t_trig
    task automatic t_store;
        mode_refresh = 1'b1;
        flag_reset_n = 1'b0;
        w(10);
        flag_reset_n = 1'b1;
        w(AUTO + 30);
        chk("ble timeout", 1'b0, brightline_enable);
        chk("auto flag", 1'b1, triggered_flag);
        run = 1'b1;
        w(40);
        chk("ble retrig", 1'b1, brightline_enable);
        chk("flag sweep end", 1'b0, triggered_flag);
        w(AUTO);
        chk("ble writing", 1'b1, brightline_enable);
        chk("no auto", 1'b0, triggered_flag);
        run = 1'b0;
        w(AUTO - 50);
        chk("ble quiet", 1'b1, brightline_enable);
        w(90);
        chk("ble expired", 1'b0, brightline_enable);
        chk("auto after write", 1'b1, triggered_flag);
        {mode_refresh, mode_roll, run, brightline_off_switch} = 4'h5;
        flag_reset_n = 1'b0;
        w(10);
        flag_reset_n = 1'b1;
        w(AUTO + 30);
        chk("switch ble", 1'b1, brightline_enable);
        chk("switch blocks", 1'b0, triggered_flag);
        mode_roll = 1'b0;
    endtask : t_store
    task automatic t_rate;
        whole_memory_view_n = 1'b0;
        w(10);
        chk("p full", 1'b1, rate_select_p);
        chk("q full", 1'b1, rate_select_q);
        whole_memory_view_n = 1'b1;
        run = 1'b1;
        for (int i = 0; i < 3; i++) begin
            {div_5_sel, div_2p5_sel} = i[1:0];
            w(80);
            for (int k = 0; k < 2; k++) begin
                odd = k[0];
                w(10);
                chk("p", 1'b1, rate_select_p);
                chk("q", i != 0, rate_select_q);
            end
        end
        alt_sample_freeze = 1'b1;
        odd = 1'b0;
        {div_5_sel, div_2p5_sel} = 2'h0;
        w(80);
        chk("q frozen", 1'b1, rate_select_q);
        odd = 1'b1;
        w(10);
        chk("q odd", 1'b0, rate_select_q);
        alt_sample_freeze = 1'b0;
        run = 1'b0;
        w(10);
        div_5_sel = 1'b1;
        w(80);
        chk("q halted", 1'b0, rate_select_q);
    endtask : t_rate
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        w(10);
        chk("rst flag", tbt_pkg::FLAG_RST_VAL, triggered_flag);
        chk("rst ble", tbt_pkg::BLE_RST_VAL, brightline_enable);
        chka(10'h0, read_addr);
        rst = 1'b0;
        w(10);
        t_trig();
        t_store();
        t_rate();
        a0 = read_addr;
        w(1000);
        chka(a0 + 10'h00a, read_addr);
        finish_test();
    end
endmodule : tbt_timebase_tb_top
bind tbt_timebase tbt_timebase_properties #(.AUTO_CYC(AUTO_CYC)) i_tbt_timebase_properties (
    .ref_clk, .rst, .trig_comp, .slope_neg, .src_line, .write_activity_pulse,
    .write_sweep_end_bit, .flag_reset_n, .holdoff_ext, .brightline_off_switch, .mode_refresh,
    .mode_roll, .whole_memory_view_n, .triggered_flag, .brightline_enable, .holdoff,
    .rate_select_p, .rate_select_q, .read_addr);
